// ---- core/rbci_pkg.sv ----
// rbci_pkg: constants and types of the reset, boot and config-integrity block
// assumes a 40 MHz hclk and a 32-bit AHB-Lite register port
package rbci_pkg;
    localparam int unsigned CLK_HZ       = 40_000_000;
    localparam int unsigned INIT_MS      = 20;
    localparam int unsigned INIT_CYC_DEF = INIT_MS * (CLK_HZ / 1000);
    localparam logic [3:0]  MIN_RST_CYC_DEF = 4'h4;
    localparam logic [3:0]  WDOG_HOLD_CYC   = 4'h4;
    // register byte offsets
    localparam logic [7:0]  A_CTRL = 8'h00;
    localparam logic [7:0]  A_CMD  = 8'h04;
    localparam logic [7:0]  A_STAT = 8'h08;
    localparam logic [7:0]  A_ADDR = 8'h0c;
    localparam logic [7:0]  A_FLA  = 8'h10;
    localparam logic [7:0]  A_FLD  = 8'h14;
    localparam logic [7:0]  A_FLIP = 8'h18;
    localparam logic [7:0]  A_CFG0 = 8'h20;
    localparam logic [7:0]  A_CFG3 = 8'h2c;
    // status bit positions
    localparam int S_CFG   = 0;
    localparam int S_LOG   = 1;
    localparam int S_FW    = 2;
    localparam int S_BLANK = 3;
    localparam int S_JTAG  = 4;
    localparam int S_RNG   = 5;
    localparam int S_ECC   = 6;
    localparam int S_UPD   = 7;
    localparam logic [31:0] CMD_STORE   = 32'h0000_0001;
    localparam logic [31:0] CMD_ERASE   = 32'h0000_0002;
    localparam logic [31:0] CFG_LIMIT   = 32'h00ff_ffff;
    localparam logic [31:0] CFG_FACTORY = 32'h0000_0000;
    localparam logic [37:0] FL_ERASED   = 38'h3f_ffff_ffff;
    localparam logic [2:0]  FL_CSUM     = 3'h4;
    localparam logic [2:0]  FL_LSUM     = 3'h7;
    localparam logic [7:0]  ADDR_JTAG   = 8'h7e;
    localparam logic [7:0]  BIN_SCALE   = 8'h0c;
    localparam logic [3:0]  BIN_MIN     = 4'h4;
    localparam logic [3:0]  BIN_MAX     = 4'hb;
    typedef enum logic [5:0] {
        ST_RESET = 6'h01,
        ST_SCAN  = 6'h02,
        ST_INIT  = 6'h04,
        ST_RUN   = 6'h08,
        ST_HALT  = 6'h10,
        ST_PROG  = 6'h20
    } rbci_state_e;
endpackage

// ---- core/rbci_top.sv ----
// rbci_top: device reset, boot checks, config staging and ECC data flash
// assumes AHB-Lite single word transfers and pins synchronous to hclk
//
// Summary of operation
// RL1 - hold reset while digital supply is below release threshold
// RL2 - reset pin low longer than minimum time holds device in reset
// RL3 - leave reset within 1 ms after the reset pin returns high
// RL4 - every reset exit runs a 20 ms initialization phase
// RL5 - during initialization fan pwm pins low, other pins undriven
// RL6 - after initialization run with the stored configuration
// RL7 - factory configuration: outputs hi-z, fans low, no sequencing
// RL8 - parameter writes touch RAM; store-all copies RAM into flash
// RL9 - host unprotects, erases, writes flash image, then resets
// RL10 - after in-operation update keep old config, fault logging off
// RL11 - test port disabled by default, its pins stay general purpose
// RL12 - blank data flash at power-up enables the test port
// RL13 - decoded address 126, shorted or open pin, enables test port
// RL14 - four of six test-port pins usable as general pins
// RL15 - firmware checksum mismatch: do not run, only serve bus
// RL16 - config checksum mismatch: factory config, alert, status flag
// RL17 - error-log region checked against its checksum
// RL18 - watchdog timeout resets; pins open-drain, fans low meanwhile
// RL19 - every received parameter is range checked
// RL20 - six check bits generated per 32-bit flash word
// RL21 - stored check bits correct single-bit errors on read
// RL22 - bus address derived from two address-detect pin bins
// RL23 - check code is single-error-correcting Hamming over 32 bits
`timescale 1ns/10ps
`default_nettype none
module rbci_top
#(
    parameter logic [19:0] INIT_CYC    = 20'(rbci_pkg::INIT_CYC_DEF),
    parameter logic [3:0]  MIN_RST_CYC = rbci_pkg::MIN_RST_CYC_DEF
)
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic [31:0] hrdata,
    output var  logic        hreadyout,
    output var  logic        hresp,
    input  wire logic        supply_ok,
    input  wire logic        reset_pin_n,
    input  wire logic        wdog_expire,
    input  wire logic [3:0]  addr_bin_hi,
    input  wire logic [3:0]  addr_bin_lo,
    input  wire logic [31:0] fw_sum_calc,
    input  wire logic [31:0] fw_sum_ref,
    output var  logic [7:0]  general_output_pins,
    output var  logic [7:0]  general_output_pins_oe,
    output var  logic [7:0]  fan_pwm_pins,
    output var  logic        test_port_en,
    output var  logic        bus_alert_line_oe,
    output var  logic        fault_log_en,
    output var  logic        dev_in_reset
);
    import rbci_pkg::*;

    function automatic logic [37:0] ecc_enc(input logic [31:0] d); //RL23
        logic [37:0] c;
        logic [5:0]  s;
        int          k;
        c = '0;
        s = '0;
        k = 0;
        for (int p = 1; p <= 38; p++)
            if ((p & (p - 1)) != 0)
            begin
                c[p-1] = d[k];
                k++;
            end
        for (int p = 1; p <= 38; p++)
            if (c[p-1])
                s = s ^ 6'(p);
        for (int i = 0; i < 6; i++)
            c[(1 << i) - 1] = s[i];
        return c;
    endfunction

    // returns {nonzero syndrome, data}; syndromes past 38 are left uncorrected
    function automatic logic [32:0] ecc_dec(input logic [37:0] cw);
        logic [37:0] c;
        logic [31:0] d;
        logic [5:0]  s;
        int          k;
        c = cw;
        d = '0;
        s = '0;
        k = 0;
        for (int p = 1; p <= 38; p++)
            if (c[p-1])
                s = s ^ 6'(p);
        if (s != 6'h00 && s <= 6'd38)
            c[int'(s) - 1] = ~c[int'(s) - 1];
        for (int p = 1; p <= 38; p++)
            if ((p & (p - 1)) != 0)
            begin
                d[k] = c[p-1];
                k++;
            end
        return {s != 6'h00, d};
    endfunction

    logic [37:0] flash [8];
    rbci_state_e st_r, st_nxt;
    logic [3:0]  rcnt_r, rcnt_nxt, wcnt_r, wcnt_nxt;
    logic [19:0] icnt_r, icnt_nxt;
    logic [2:0]  idx_r, idx_nxt, fla_r, fla_nxt;
    logic [31:0] sum_r, sum_nxt;
    logic [31:0] ram_r [4];
    logic [31:0] ram_nxt [4];
    logic [7:0]  addr_r, addr_nxt, ph_a_r, ph_a_nxt;
    logic [7:0]  flag_r, flag_nxt;
    logic [5:0]  flip_r, flip_nxt;
    logic        wp_off_r, wp_off_nxt, erase_r, erase_nxt;
    logic        ph_v_r, ph_v_nxt, ph_we_r, ph_we_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic [7:0]  gpo_r, gpo_nxt, oe_r, oe_nxt, pwm_r, pwm_nxt;
    logic        jtag_r, jtag_nxt, alert_r, alert_nxt;
    logic        logen_r, logen_nxt, inrst_r, inrst_nxt;
    logic        fw_en;
    logic [2:0]  fw_a;
    logic [37:0] fw_d;
    logic        dev_rst;
    logic [32:0] dec;
    logic [32:0] dec_rd;
    logic [37:0] flipmask;
    logic [7:0]  bin_addr;
    logic        wr_cmd;

    assign flipmask = (flip_r == 6'h00 || flip_r > 6'd38) ? 38'h0 :
                      38'h1 << (flip_r - 6'h01);
    assign wr_cmd   = ph_v_r && ph_we_r && ph_a_r == A_CMD;
    assign bin_addr = 8'({4'h0, addr_bin_hi}) * BIN_SCALE
                      + 8'({4'h0, addr_bin_lo});

    always_comb
    begin
        st_nxt     = st_r;
        rcnt_nxt   = reset_pin_n ? 4'h0 :
                     (rcnt_r == MIN_RST_CYC ? rcnt_r : rcnt_r + 4'h1);
        wcnt_nxt   = wdog_expire ? WDOG_HOLD_CYC :
                     (wcnt_r != 4'h0 ? wcnt_r - 4'h1 : 4'h0);
        // supply, held-low pin or watchdog hold keep the device in reset
        dev_rst    = !supply_ok //RL1
                     || (!reset_pin_n && rcnt_r == MIN_RST_CYC) //RL2
                     || wcnt_r != 4'h0; //RL18
        icnt_nxt   = icnt_r;
        idx_nxt    = idx_r;
        fla_nxt    = fla_r;
        sum_nxt    = sum_r;
        ram_nxt    = ram_r;
        addr_nxt   = addr_r;
        flag_nxt   = flag_r;
        flip_nxt   = flip_r;
        wp_off_nxt = wp_off_r;
        erase_nxt  = erase_r;
        jtag_nxt   = jtag_r;
        fw_en      = 1'b0;
        fw_a       = idx_r;
        fw_d       = FL_ERASED;
        dec        = ecc_dec(flash[idx_r]); //RL21
        ph_v_nxt   = hsel && htrans[1] && hready && haddr[31:8] == 24'h0;
        ph_we_nxt  = hwrite;
        ph_a_nxt   = haddr[7:0];
        case (st_r)
            ST_RESET:
            begin
                if (!dev_rst)
                begin
                    st_nxt   = ST_SCAN; //RL3
                    idx_nxt  = 3'h0;
                    sum_nxt  = 32'h0;
                    flag_nxt = 8'h08;
                    // bins outside 4..11 mean a shorted or open pin
                    if (addr_bin_hi < BIN_MIN || addr_bin_hi > BIN_MAX
                        || addr_bin_lo < BIN_MIN || addr_bin_lo > BIN_MAX)
                        addr_nxt = ADDR_JTAG; //RL13
                    else
                        addr_nxt = bin_addr; //RL22
                end
            end
            ST_SCAN:
            begin
                if (flash[idx_r] != FL_ERASED)
                    flag_nxt[S_BLANK] = 1'b0;
                if (dec[32])
                    flag_nxt[S_ECC] = 1'b1;
                idx_nxt = idx_r + 3'h1;
                if (idx_r < FL_CSUM)
                begin
                    ram_nxt[idx_r[1:0]] = dec[31:0]; //RL6
                    sum_nxt = sum_r + dec[31:0];
                end
                else if (idx_r == FL_CSUM)
                begin
                    sum_nxt = 32'h0;
                    if (sum_r != dec[31:0])
                    begin
                        flag_nxt[S_CFG] = 1'b1; //RL16
                        for (int i = 0; i < 4; i++)
                            ram_nxt[i] = CFG_FACTORY; //RL7
                    end
                end
                else if (idx_r < FL_LSUM)
                    sum_nxt = sum_r + dec[31:0];
                else
                begin
                    flag_nxt[S_LOG] = sum_r != dec[31:0]; //RL17
                    flag_nxt[S_FW]  = fw_sum_calc != fw_sum_ref; //RL15
                    jtag_nxt = flag_nxt[S_BLANK] //RL12
                               || addr_r == ADDR_JTAG; //RL13
                    st_nxt   = ST_INIT; //RL4
                    icnt_nxt = 20'h0;
                end
            end
            ST_INIT:
            begin
                icnt_nxt = icnt_r + 20'h1;
                if (icnt_r == INIT_CYC - 20'h1)
                    st_nxt = flag_r[S_FW] ? ST_HALT : ST_RUN; //RL15
            end
            ST_PROG:
            begin
                fw_en   = 1'b1;
                idx_nxt = idx_r + 3'h1;
                if (erase_r)
                    fw_d = FL_ERASED;
                else if (idx_r < FL_CSUM)
                    fw_d = ecc_enc(ram_r[idx_r[1:0]]); //RL20
                else
                    fw_d = ecc_enc(ram_r[0] + ram_r[1]
                                   + ram_r[2] + ram_r[3]);
                if (idx_r == (erase_r ? FL_LSUM : FL_CSUM))
                    st_nxt = ST_RUN;
            end
            default:
            begin
            end
        endcase
        if (ph_v_r && ph_we_r)
        begin
            if (ph_a_r == A_CTRL)
                wp_off_nxt = hwdata[0];
            else if (ph_a_r == A_CMD && st_r == ST_RUN)
            begin
                if (hwdata == CMD_STORE)
                begin
                    st_nxt    = ST_PROG; //RL8
                    erase_nxt = 1'b0;
                    idx_nxt   = 3'h0;
                end
                else if (hwdata == CMD_ERASE && wp_off_r)
                begin
                    st_nxt          = ST_PROG; //RL9
                    erase_nxt       = 1'b1;
                    idx_nxt         = 3'h0;
                    flag_nxt[S_UPD] = 1'b1; //RL10
                end
            end
            else if (ph_a_r == A_STAT)
            begin
                flag_nxt[S_CFG] = flag_r[S_CFG] & ~hwdata[S_CFG];
                flag_nxt[S_RNG] = flag_r[S_RNG] & ~hwdata[S_RNG];
                flag_nxt[S_ECC] = flag_nxt[S_ECC] & ~hwdata[S_ECC];
            end
            else if (ph_a_r == A_FLA)
                fla_nxt = hwdata[2:0];
            else if (ph_a_r == A_FLD && wp_off_r && st_r == ST_RUN)
            begin
                fw_en           = 1'b1;
                fw_a            = fla_r;
                fw_d            = ecc_enc(hwdata) ^ flipmask; //RL20
                flip_nxt        = 6'h00;
                flag_nxt[S_UPD] = 1'b1; //RL10
            end
            else if (ph_a_r == A_FLIP)
                flip_nxt = hwdata[5:0];
            else if (ph_a_r >= A_CFG0 && ph_a_r <= A_CFG3)
            begin
                if (hwdata <= CFG_LIMIT) //RL19
                    ram_nxt[ph_a_r[3:2]] = hwdata; //RL8
                else
                    flag_nxt[S_RNG] = 1'b1; //RL19
            end
        end
        hrdata_nxt = 32'h0;
        dec_rd     = ecc_dec(flash[fla_nxt]);
        if (ph_v_nxt && !hwrite)
        begin
            if (haddr[7:0] == A_CTRL)
                hrdata_nxt = {31'h0, wp_off_nxt};
            else if (haddr[7:0] == A_STAT)
                hrdata_nxt = {18'h0, st_nxt, flag_nxt};
            else if (haddr[7:0] == A_ADDR)
                hrdata_nxt = {24'h0, addr_nxt};
            else if (haddr[7:0] == A_FLA)
                hrdata_nxt = {29'h0, fla_nxt};
            else if (haddr[7:0] == A_FLD)
            begin
                hrdata_nxt = dec_rd[31:0]; //RL21
                if (dec_rd[32])
                    flag_nxt[S_ECC] = 1'b1;
            end
            else if (haddr[7:0] == A_FLIP)
                hrdata_nxt = {26'h0, flip_nxt};
            else if (haddr[7:0] >= A_CFG0 && haddr[7:0] <= A_CFG3)
                hrdata_nxt = ram_nxt[haddr[3:2]];
        end
        if (dev_rst)
        begin
            st_nxt     = ST_RESET;
            wp_off_nxt = 1'b0;
            jtag_nxt   = 1'b0; //RL11
            flag_nxt[S_UPD] = 1'b0;
        end
        flag_nxt[S_JTAG] = jtag_nxt;
        // pins follow the config only in the run and program states
        if (st_nxt == ST_RUN || st_nxt == ST_PROG)
        begin
            oe_nxt  = ram_nxt[0][7:0]; //RL6
            gpo_nxt = ram_nxt[0][15:8];
            pwm_nxt = ram_nxt[0][23:16];
            if (jtag_nxt)
                oe_nxt[3:0] = 4'h0; //RL14
        end
        else
        begin
            oe_nxt  = 8'h00; //RL5
            gpo_nxt = 8'h00;
            pwm_nxt = 8'h00; //RL18
        end
        alert_nxt = flag_nxt[S_CFG]; //RL16
        logen_nxt = (st_nxt == ST_RUN || st_nxt == ST_PROG)
                    && !flag_nxt[S_UPD]; //RL10
        inrst_nxt = st_nxt == ST_RESET;
    end

    // nonvolatile array: bus reset models a fresh, erased part
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < 8; i++)
                flash[i] <= FL_ERASED;
        end
        else if (fw_en)
            flash[fw_a] <= fw_d;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_r     <= ST_RESET;
            rcnt_r   <= 4'h0;
            wcnt_r   <= 4'h0;
            icnt_r   <= 20'h0;
            idx_r    <= 3'h0;
            fla_r    <= 3'h0;
            sum_r    <= 32'h0;
            for (int i = 0; i < 4; i++)
                ram_r[i] <= CFG_FACTORY;
            addr_r   <= 8'h00;
            flag_r   <= 8'h00;
            flip_r   <= 6'h00;
            wp_off_r <= 1'b0;
            erase_r  <= 1'b0;
            ph_v_r   <= 1'b0;
            ph_we_r  <= 1'b0;
            ph_a_r   <= 8'h00;
            hrdata_r <= 32'h0;
            gpo_r    <= 8'h00;
            oe_r     <= 8'h00;
            pwm_r    <= 8'h00;
            jtag_r   <= 1'b0;
            alert_r  <= 1'b0;
            logen_r  <= 1'b0;
            inrst_r  <= 1'b1;
        end
        else
        begin
            st_r     <= st_nxt;
            rcnt_r   <= rcnt_nxt;
            wcnt_r   <= wcnt_nxt;
            icnt_r   <= icnt_nxt;
            idx_r    <= idx_nxt;
            fla_r    <= fla_nxt;
            sum_r    <= sum_nxt;
            ram_r    <= ram_nxt;
            addr_r   <= addr_nxt;
            flag_r   <= flag_nxt;
            flip_r   <= flip_nxt;
            wp_off_r <= wp_off_nxt;
            erase_r  <= erase_nxt;
            ph_v_r   <= ph_v_nxt;
            ph_we_r  <= ph_we_nxt;
            ph_a_r   <= ph_a_nxt;
            hrdata_r <= hrdata_nxt;
            gpo_r    <= gpo_nxt;
            oe_r     <= oe_nxt;
            pwm_r    <= pwm_nxt;
            jtag_r   <= jtag_nxt;
            alert_r  <= alert_nxt;
            logen_r  <= logen_nxt;
            inrst_r  <= inrst_nxt;
        end
    end

    assign hrdata                 = hrdata_r;
    assign hreadyout              = 1'b1;
    assign hresp                  = 1'b0;
    assign general_output_pins    = gpo_r;
    assign general_output_pins_oe = oe_r;
    assign fan_pwm_pins           = pwm_r;
    assign test_port_en           = jtag_r;
    assign bus_alert_line_oe      = alert_r;
    assign fault_log_en           = logen_r;
    assign dev_in_reset           = inrst_r;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence store_req;
        wr_cmd && hwdata == CMD_STORE && st_r == ST_RUN && !dev_rst;
    endsequence
    sequence store_walk;
        st_r == ST_PROG [*5] ##1 st_r == ST_RUN;
    endsequence

    chk_supply_low: assert property ( //RL1
        !supply_ok |=> dev_in_reset)
        else $error("reset not held with supply low");
    chk_pin_held: assert property ( //RL2
        !reset_pin_n && rcnt_r == MIN_RST_CYC |=> dev_in_reset)
        else $error("reset not held with pin low");
    chk_exit_fast: assert property ( //RL3
        $rose(reset_pin_n) && supply_ok && !wdog_expire && wcnt_r == 4'h0
        ##1 (reset_pin_n && supply_ok && !wdog_expire)[*2]
        |-> !dev_in_reset)
        else $error("slow exit from reset");
    chk_init_end: assert property ( //RL4
        st_r == ST_INIT && icnt_r == INIT_CYC - 20'h1 && !dev_rst
        |=> st_r == ST_RUN || st_r == ST_HALT)
        else $error("init phase did not end on time");
    chk_init_pins: assert property ( //RL5
        st_r inside {ST_RESET, ST_SCAN, ST_INIT, ST_HALT}
        |-> fan_pwm_pins == 8'h00 && general_output_pins_oe == 8'h00)
        else $error("pins driven outside normal operation");
    chk_run_cfg: assert property ( //RL6
        st_r == ST_RUN && !test_port_en
        |-> general_output_pins_oe == ram_r[0][7:0]
            && fan_pwm_pins == ram_r[0][23:16])
        else $error("pins do not follow configuration");
    chk_store_seq: assert property ( //RL8
        store_req |=> store_walk)
        else $error("store-all walk wrong");
    chk_upd_nolog: assert property ( //RL10
        flag_r[S_UPD] |-> !fault_log_en)
        else $error("logging active after flash update");
    chk_jtag_addr: assert property ( //RL13
        st_r == ST_INIT && addr_r == ADDR_JTAG |-> test_port_en)
        else $error("test port not enabled for address 126");
    chk_fw_halt: assert property ( //RL15
        st_r == ST_INIT && icnt_r == INIT_CYC - 20'h1 && !dev_rst
        && flag_r[S_FW] |=> st_r == ST_HALT)
        else $error("bad firmware was run");
    chk_cfg_alert: assert property ( //RL16
        flag_r[S_CFG] |-> bus_alert_line_oe)
        else $error("alert not asserted on config error");
    chk_ecc_fix: assert property ( //RL21
        flip_r <= 6'd38 |->
        ecc_dec(ecc_enc(hwdata) ^ flipmask) == {flip_r != 6'h00, hwdata})
        else $error("single-bit error not corrected");
endmodule
`default_nettype wire

// ---- bench/rbci_host.sv ----
// rbci_host: host controller model, single-word ahb-lite master
// assumes hready is the lone slave's hreadyout
`timescale 1ns/10ps
`default_nettype none
module rbci_host
(
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output var  logic        hsel,
    output var  logic [31:0] haddr,
    output var  logic [1:0]  htrans,
    output var  logic        hwrite,
    output var  logic [2:0]  hsize,
    output var  logic [31:0] hwdata
);
    initial
    begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h0;
    end

    // released address and data lines show the inverse, never a stale value
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        haddr <= ~{24'h0, a};
        htrans <= 2'h0;
        hwdata <= w ? wd : ~wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        hwdata <= ~wd;
    endtask
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// testbench: boot, staging, ecc, update and reset scenarios
// assumes a 40 MHz hclk and a shortened init count
`timescale 1ns/10ps
`default_nettype none
`define CK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module testbench;
    import rbci_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        supply_ok = 1'b1;
    logic        reset_pin_n = 1'b1;
    logic        wdog_expire = 1'b0;
    logic [3:0]  addr_bin_hi = 4'h5;
    logic [3:0]  addr_bin_lo = 4'h6;
    logic [31:0] fw_sum_calc = 32'h5a5a_0000;
    logic [31:0] fw_sum_ref = 32'h5a5a_0000;
    wire logic        hsel, hwrite, hreadyout, hresp, test_port_en;
    wire logic        bus_alert_line_oe, fault_log_en, dev_in_reset;
    wire logic [1:0]  htrans;
    wire logic [2:0]  hsize;
    wire logic [31:0] haddr, hwdata, hrdata;
    wire logic [7:0]  general_output_pins, general_output_pins_oe;
    wire logic [7:0]  fan_pwm_pins;
    int errors = 0;
    int checked = 0;
    logic [31:0] d;

    always #12.5 hclk = ~hclk;

    rbci_host i_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hwdata(hwdata), .hsize(hsize));
    rbci_top #(.INIT_CYC(20'd20)) i_dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .supply_ok(supply_ok), .reset_pin_n(reset_pin_n),
        .wdog_expire(wdog_expire), .addr_bin_hi(addr_bin_hi),
        .addr_bin_lo(addr_bin_lo), .fw_sum_calc(fw_sum_calc),
        .fw_sum_ref(fw_sum_ref), .general_output_pins(general_output_pins),
        .general_output_pins_oe(general_output_pins_oe),
        .fan_pwm_pins(fan_pwm_pins), .test_port_en(test_port_en),
        .bus_alert_line_oe(bus_alert_line_oe), .fault_log_en(fault_log_en),
        .dev_in_reset(dev_in_reset));

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        i_host.xfer(1'b0, a, 32'h0, v);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] x;
        i_host.xfer(1'b1, a, v, x);
    endtask
    task automatic wait_st(input logic [5:0] s);
        int n;
        n = 0;
        do
        begin
            rd(A_STAT, d);
            n++;
        end while (d[13:8] !== s && n < 400);
        `CK("state", s, d[13:8])
    endtask
    // init phase with idle pins, then the expected final state
    task automatic init_chk(input logic [5:0] s);
        wait_st(ST_INIT);
        `CK("init pwm", 8'h0, fan_pwm_pins)
        `CK("init oe", 8'h0, general_output_pins_oe)
        wait_st(s);
    endtask
    task automatic pin_rst(input logic [3:0] hi, input logic [3:0] lo);
        int n;
        addr_bin_hi <= hi;
        addr_bin_lo <= lo;
        reset_pin_n <= 1'b0;
        repeat (8) @(posedge hclk);
        `CK("pin held", 1'b1, dev_in_reset)
        reset_pin_n <= 1'b1;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end while (dev_in_reset !== 1'b0 && n < 40000);
        `CK("pin exit", 1'b0, dev_in_reset)
        init_chk(ST_RUN);
    endtask
    task automatic t_boot;
        init_chk(ST_RUN);
        rd(A_STAT, d);
        `CK("cfg bad", 1'b1, d[S_CFG])
        `CK("log bad", 1'b1, d[S_LOG])
        `CK("hresp", 1'b0, hresp)
        `CK("blank", 1'b1, d[S_BLANK])
        `CK("alert", 1'b1, bus_alert_line_oe)
        `CK("tport", 1'b1, test_port_en)
        `CK("factory", 16'h0, {general_output_pins_oe, fan_pwm_pins})
    endtask
    task automatic t_cfg;
        wr(A_CFG0, 32'h0055_a5ff);
        repeat (2) @(posedge hclk);
        `CK("oe tport", 8'hf0, general_output_pins_oe)
        `CK("out", 8'ha5, general_output_pins)
        `CK("pwm", 8'h55, fan_pwm_pins)
        wr(A_CFG0 + 8'h4, CFG_LIMIT + 32'h1);
        rd(A_CFG0 + 8'h4, d);
        `CK("range drop", CFG_FACTORY, d)
        rd(A_STAT, d);
        `CK("range flag", 1'b1, d[S_RNG])
        wr(A_CMD, CMD_STORE);
        wait_st(ST_RUN);
        wr(A_FLA, 32'h0);
        rd(A_FLD, d);
        `CK("stored", 32'h0055_a5ff, d)
    endtask
    task automatic t_addr;
        pin_rst(4'h5, 4'h6);
        rd(A_ADDR, d);
        `CK("addr", BIN_SCALE * 8'h5 + 8'h6, d[7:0])
        `CK("tport off", 1'b0, test_port_en)
        `CK("oe full", 8'hff, general_output_pins_oe)
        pin_rst(4'h0, 4'h6);
        rd(A_ADDR, d);
        `CK("addr dflt", ADDR_JTAG, d[7:0])
        `CK("tport on", 1'b1, test_port_en)
    endtask
    task automatic t_ecc_upd;
        `CK("log on", 1'b1, fault_log_en)
        wr(A_CTRL, 32'h1);
        wr(A_FLA, 32'h2);
        wr(A_FLIP, 32'h5);
        wr(A_STAT, 32'h1 << S_ECC);
        rd(A_STAT, d);
        `CK("ecc clr", 1'b0, d[S_ECC])
        wr(A_FLD, 32'h1234_5678);
        rd(A_FLD, d);
        `CK("ecc fix", 32'h1234_5678, d)
        rd(A_STAT, d);
        `CK("ecc flag", 1'b1, d[S_ECC])
        wr(A_CMD, CMD_ERASE);
        wait_st(ST_RUN);
        wr(A_FLA, 32'h0);
        wr(A_FLD, 32'h0000_00ff);
        rd(A_STAT, d);
        `CK("upd flag", 1'b1, d[S_UPD])
        `CK("log off", 1'b0, fault_log_en)
        `CK("old cfg", 8'ha5, general_output_pins)
    endtask
    task automatic t_wdog_fw;
        wdog_expire <= 1'b1;
        @(posedge hclk);
        wdog_expire <= 1'b0;
        repeat (2) @(posedge hclk);
        `CK("wd rst", 1'b1, dev_in_reset)
        `CK("wd pins", 16'h0, {general_output_pins_oe, fan_pwm_pins})
        init_chk(ST_RUN);
        fw_sum_calc <= 32'h0000_0001;
        supply_ok <= 1'b0;
        repeat (4) @(posedge hclk);
        `CK("supply rst", 1'b1, dev_in_reset)
        supply_ok <= 1'b1;
        init_chk(ST_HALT);
        rd(A_STAT, d);
        `CK("fw bad", 1'b1, d[S_FW])
        `CK("halt oe", 8'h0, general_output_pins_oe)
    endtask
    task automatic test_done;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        t_boot();
        t_cfg();
        t_addr();
        t_ecc_upd();
        t_wdog_fw();
        test_done();
    end
    initial
    begin
        #(25 * 40000);
        errors++;
        test_done();
    end
endmodule
`default_nettype wire
